// ### cwr_pkg.sv
// Purpose: Shared constants and types for the CPU watchdog reset block
// Assumes: Byte-wide I/O port accesses, 10-bit port address, 25 MHz clock
// Notes:   Port offsets are the full I/O addresses
package cwr_pkg;

  // I/O port addresses
  localparam logic [9:0] CTRL_PORT_ADDR   = 10'h1d0;
  localparam logic [9:0] HOLDOFF_PORT_ADDR = 10'h1d1;
  localparam logic [9:0] STATUS_PORT_ADDR = 10'h1d2;

  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_FLAG_BIT = 2;

  // Values
  localparam logic [7:0] HOLDOFF_KEY   = 8'h5a;
  localparam logic       ENABLE_RESET  = 1'b0;
  localparam logic       FLAG_RESET    = 1'b0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WDOG_PERIOD_MS = 1000;
  localparam int unsigned WDOG_PERIOD_CYCLES =
    (WDOG_PERIOD_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W = 25;
  localparam int unsigned CPU_RESET_HOLD_CYCLES = 16;
  localparam int          HOLD_W = 5;

  typedef enum logic [1:0] {
    PORT_NONE = 2'b00,
    PORT_CTRL = 2'b01,
    PORT_HOLD = 2'b10,
    PORT_STAT = 2'b11
  } cwr_port_e;

  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cwr_io_req_s;

endpackage

// ### cwr_timer.sv
// Purpose: Fixed-period free-running watchdog counter
// Assumes: PERIOD_CYCLES of at least two
// Notes:   Expire pulses once per period; restart wins over wrap
`timescale 1ns/1ps
`default_nettype none
module cwr_timer
  import cwr_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = WDOG_PERIOD_CYCLES
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             restart,
  output logic                  expire,
  output logic [CNT_W-1:0]      count
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W:0]   FULL = (CNT_W+1)'(PERIOD_CYCLES);

  // No register reaches the length, so it cannot be shortened by software
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      expire <= 1'b0;
    end else begin
      expire <= !restart && (count == LAST);
    end
  end

  // Cycles since the count last stood at zero
  logic [CNT_W:0] since;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      since <= '0;
    end else if (restart) begin
      since <= '0;
    end else if (expire) begin
      since <= (CNT_W+1)'(1);
    end else if (since != '1) begin
      since <= since + 1'b1;
    end
  end

  property p_restart_zero;
    @(posedge mclk) disable iff (reset)
      restart |=> (count == '0) && !expire;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("restart did not clear the count");

  property p_fixed_period;
    @(posedge mclk) disable iff (reset)
      expire |-> (since == FULL);
  endproperty
  a_fixed_period: assert property (p_fixed_period)
    else $error("expiry came at a wrong period");

endmodule
`default_nettype wire

// ### cwr_top.sv
// Purpose: Watchdog that resets the host CPU when not refreshed in time
// Assumes: I/O strobes come from logic on mclk, one cycle each
// Notes:   Timer runs even while disabled so the flag can be polled
`timescale 1ns/1ps
`default_nettype none
module cwr_top
  import cwr_pkg::*;
#(
  parameter int unsigned PERIOD_CYCLES = WDOG_PERIOD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire cwr_io_req_s io_req,
  output logic [7:0]       io_rdata,
  output logic             io_rd_ack,
  output logic             cpu_reset_out
);

  function automatic cwr_port_e port_sel(input logic [9:0] addr);
    if (addr == CTRL_PORT_ADDR) begin
      port_sel = PORT_CTRL;
    end else if (addr == HOLDOFF_PORT_ADDR) begin
      port_sel = PORT_HOLD;
    end else if (addr == STATUS_PORT_ADDR) begin
      port_sel = PORT_STAT;
    end else begin
      port_sel = PORT_NONE;
    end
  endfunction

  cwr_port_e        wr_port;
  cwr_port_e        rd_port;
  logic             wr_ctrl;
  logic             wr_hold;
  logic             wr_stat;
  logic             restart;
  logic             expire;
  logic [CNT_W-1:0] tmr_count;
  logic             wd_enable;
  logic             expiry_flag;
  logic [HOLD_W-1:0] hold_cnt;
  logic [7:0]       next_rdata;

  assign wr_port = io_req.wr ? port_sel(io_req.addr) : PORT_NONE;
  assign rd_port = port_sel(io_req.addr);
  assign wr_ctrl = (wr_port == PORT_CTRL);
  assign wr_hold = (wr_port == PORT_HOLD);
  assign wr_stat = (wr_port == PORT_STAT);
  // Only the exact key restarts; anything else is dropped
  assign restart = wr_hold && (io_req.wdata == HOLDOFF_KEY);

  cwr_timer #(
    .PERIOD_CYCLES (PERIOD_CYCLES)
  ) u_timer (
    .mclk    (mclk),
    .reset   (reset),
    .restart (restart),
    .expire  (expire),
    .count   (tmr_count)
  );

  // Enable: written directly, no unlock sequence
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wd_enable <= ENABLE_RESET;
    end else if (wr_ctrl) begin
      wd_enable <= io_req.wdata[CTRL_EN_BIT];
    end
  end

  // Expiry flag: set beats a clear in the same cycle
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      expiry_flag <= FLAG_RESET;
    end else if (expire) begin
      expiry_flag <= 1'b1;
    end else if (wr_stat && io_req.wdata[STAT_FLAG_BIT]) begin
      expiry_flag <= 1'b0;
    end
  end

  // CPU reset stretched so a slow reset input sees it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hold_cnt      <= '0;
      cpu_reset_out <= 1'b0;
    end else if (expire && wd_enable) begin
      hold_cnt      <= HOLD_W'(CPU_RESET_HOLD_CYCLES - 1);
      cpu_reset_out <= 1'b1;
    end else if (hold_cnt != '0) begin
      hold_cnt      <= hold_cnt - 1'b1;
      cpu_reset_out <= 1'b1;
    end else begin
      cpu_reset_out <= 1'b0;
    end
  end

  // Unused control bits read zero; software keeps them via read-modify-write
  always_comb begin
    next_rdata = UNMAPPED_READ;
    case (rd_port)
      PORT_CTRL: begin
        next_rdata = 8'h00;
        next_rdata[CTRL_EN_BIT] = wd_enable;
      end
      PORT_STAT: begin
        next_rdata = 8'h00;
        next_rdata[STAT_FLAG_BIT] = expiry_flag;
      end
      PORT_HOLD: begin
        next_rdata = 8'h00;
      end
      default: begin
        next_rdata = UNMAPPED_READ;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (io_req.rd) begin
      io_rdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      io_rd_ack <= 1'b0;
    end else begin
      io_rd_ack <= io_req.rd;
    end
  end

  property p_expire_reset;
    @(posedge mclk) disable iff (reset)
      expire && wd_enable |=> cpu_reset_out [*8];
  endproperty
  a_expire_reset: assert property (p_expire_reset)
    else $error("enabled expiry did not reset the CPU");

  property p_no_reset_disabled;
    @(posedge mclk) disable iff (reset)
      !wd_enable && !cpu_reset_out |=> !cpu_reset_out;
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled)
    else $error("CPU reset while watchdog disabled");

  property p_reset_disabled;
    @(posedge mclk) disable iff (reset)
      $past(reset) |-> !wd_enable && !cpu_reset_out;
  endproperty
  a_reset_disabled: assert property (p_reset_disabled)
    else $error("watchdog not disabled after reset");

  property p_disable_now;
    @(posedge mclk) disable iff (reset)
      wr_ctrl && !io_req.wdata[CTRL_EN_BIT] |=> !wd_enable;
  endproperty
  a_disable_now: assert property (p_disable_now)
    else $error("clearing enable did not disable");

  property p_key_restart;
    @(posedge mclk) disable iff (reset)
      restart |=> (tmr_count == '0) ##1
        ((tmr_count == CNT_W'(1)) || $past(restart));
  endproperty
  a_key_restart: assert property (p_key_restart)
    else $error("key write did not restart the period");

  property p_other_ignored;
    @(posedge mclk) disable iff (reset)
      wr_hold && (io_req.wdata != HOLDOFF_KEY) |=>
        (tmr_count == CNT_W'($past(tmr_count) + 1'b1)) ||
        (tmr_count == '0);
  endproperty
  a_other_ignored: assert property (p_other_ignored)
    else $error("non-key hold-off write disturbed the timer");

  property p_flag_clear;
    @(posedge mclk) disable iff (reset)
      wr_stat && io_req.wdata[STAT_FLAG_BIT] && !expire |=> !expiry_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("writing one did not clear the flag");

  property p_flag_keep;
    @(posedge mclk) disable iff (reset)
      wr_stat && !io_req.wdata[STAT_FLAG_BIT] && expiry_flag
        |=> expiry_flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep)
    else $error("writing zero changed the flag");

  property p_set_wins;
    @(posedge mclk) disable iff (reset)
      expire |=> expiry_flag;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("expiry did not set the flag");

  property p_read_flag;
    @(posedge mclk) disable iff (reset)
      io_req.rd && (rd_port == PORT_STAT) |=>
        io_rd_ack && (io_rdata[STAT_FLAG_BIT] == $past(expiry_flag));
  endproperty
  a_read_flag: assert property (p_read_flag)
    else $error("status read returned a wrong flag");

  property p_cov_reset;
    @(posedge mclk) disable iff (reset) expire && wd_enable;
  endproperty
  c_cov_reset: cover property (p_cov_reset);

  property p_cov_refresh;
    @(posedge mclk) disable iff (reset) restart && wd_enable;
  endproperty
  c_cov_refresh: cover property (p_cov_refresh);

  property p_cov_clear_race;
    @(posedge mclk) disable iff (reset)
      expire && wr_stat && io_req.wdata[STAT_FLAG_BIT];
  endproperty
  c_cov_clear_race: cover property (p_cov_clear_race);

endmodule
`default_nettype wire

// ### cwr_cpu_model.sv
// Purpose: Host CPU reset input as seen from the watchdog
// Assumes: Reset pulse is sampled on mclk rising edges
// Notes:   Counts pulses and keeps the width of the last one
`timescale 1ns/1ps
`default_nettype none
module cwr_cpu_model (
  input  wire logic mclk,
  input  wire logic cpu_reset_out,
  output var  int   pulses,
  output var  int   width,
  output var  time  rise_t
);
  int run;

  initial begin
    pulses = 0;
    width = 0;
    rise_t = 0;
    run = 0;
  end

  // Each rise restarts the host, so it counts as one recovery
  always @(posedge cpu_reset_out) begin
    pulses++;
    rise_t = $time;
  end

  // Width only known once the pulse has ended
  always @(posedge mclk) begin
    if (cpu_reset_out === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      width <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

// ### cwr_top_tb_top.sv
// Purpose: Self-checking bench for the CPU watchdog reset block
// Assumes: Period shortened to 20 cycles
// Notes:   Tasks stand in for the host software port accesses
`timescale 1ns/1ps
`default_nettype none
module cwr_top_tb_top import cwr_pkg::*;;
  localparam int P = 20;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  cwr_io_req_s io_req = '0;
  logic [7:0]  io_rdata;
  logic        io_rd_ack;
  logic        cpu_reset_out;
  int          pulses;
  int          width;
  int          failures = 0;
  int          compares = 0;
  int          n;
  time         rise_t;
  time         t0;
  time         t_key;
  logic [7:0]  d;

  always #20 mclk = ~mclk;

  cwr_top #(.PERIOD_CYCLES(P)) uut (.mclk(mclk), .reset(reset),
    .io_req(io_req), .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
    .cpu_reset_out(cpu_reset_out));
  cwr_cpu_model cpu (.mclk(mclk), .cpu_reset_out(cpu_reset_out),
    .pulses(pulses), .width(width), .rise_t(rise_t));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge mclk);
    io_req <= {a, v, 1'b1, 1'b0};
    @(posedge mclk);
    t0 = $time;
    io_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a);
    int k;
    k = 0;
    @(posedge mclk);
    io_req <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    io_req.rd <= 1'b0;
    #1;
    while (io_rd_ack !== 1'b1 && k < 4) begin
      @(posedge mclk);
      #1;
      k++;
    end
    if (k == 4) begin
      failures++;
      end_of_test();
    end
    d = io_rdata;
  endtask

  task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  task automatic end_of_test;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    rdc(CTRL_PORT_ADDR, 8'h00);
    rdc(STATUS_PORT_ADDR, 8'h00);
    rdc(HOLDOFF_PORT_ADDR, 8'h00);
    rdc(10'h3ff, UNMAPPED_READ);
    wr(STATUS_PORT_ADDR, 8'h04);
    n = 0;
    d = 8'h00;
    // Poll is bounded so a dead timer cannot hang the run
    while (d[STAT_FLAG_BIT] !== 1'b1) begin
      if (n++ == 40) begin
        failures++;
        end_of_test();
      end
      rd(STATUS_PORT_ADDR);
    end
    wr(STATUS_PORT_ADDR, 8'h00);
    rdc(STATUS_PORT_ADDR, 8'h04);
    wr(STATUS_PORT_ADDR, 8'h04);
    rdc(STATUS_PORT_ADDR, 8'h00);
    chk(pulses, 0);
    wr(HOLDOFF_PORT_ADDR, HOLDOFF_KEY);
    t_key = t0;
    rd(CTRL_PORT_ADDR);
    wr(CTRL_PORT_ADDR, d | 8'h01);
    rdc(CTRL_PORT_ADDR, 8'h01);
    wr(HOLDOFF_PORT_ADDR, 8'ha5);
    n = 0;
    while (pulses == 0) begin
      if (n++ == 60) begin
        failures++;
        end_of_test();
      end
      @(posedge mclk);
    end
    chk(32'(rise_t - t_key), 32'((P + 1) * 40));
    repeat (6) begin
      wr(HOLDOFF_PORT_ADDR, HOLDOFF_KEY);
      repeat (12) @(posedge mclk);
    end
    chk(pulses, 1);
    chk(width, CPU_RESET_HOLD_CYCLES);
    wr(CTRL_PORT_ADDR, 8'h00);
    repeat (3 * P) @(posedge mclk);
    chk(pulses, 1);
    rdc(STATUS_PORT_ADDR, 8'h04);
    wr(CTRL_PORT_ADDR, 8'h01);
    @(posedge mclk);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rdc(CTRL_PORT_ADDR, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
